// file: shared/i2c_slave_defines.svh
`ifndef I2C_SLAVE_DEFINES_SVH
`define I2C_SLAVE_DEFINES_SVH

// Register byte offsets on the APB side.
`define CONTROL_REG_OFS        8'h00
`define SLAVE_ADDRESS_REG_OFS  8'h08
`define DATA_CMD_REG_OFS       8'h10
`define MASKED_STATUS_REG_OFS  8'h2c
`define INTERRUPT_MASK_REG_OFS 8'h30
`define RAW_STATUS_REG_OFS     8'h34
`define FIFO_THRESHOLD_REG_OFS 8'h38
`define CLEAR_OVERFLOW_REG_OFS 8'h4c
`define CLEAR_READREQ_REG_OFS  8'h50
`define CLEAR_ABORT_REG_OFS    8'h54
`define ENABLE_REG_OFS         8'h6c
`define STATUS_REG_OFS         8'h70

// Control field positions.
`define CTRL_MASTER_BIT  0
`define CTRL_TENBIT_BIT  3
`define CTRL_SLVDIS_BIT  6

// Raw and masked status field positions.
`define ST_RXOVER_BIT    1
`define ST_RXFULL_BIT    2
`define ST_RDREQ_BIT     5
`define ST_ABORT_BIT     6

// Data command and status field positions.
`define DATA_CMD_BIT     8
`define STAT_ACTIVE_BIT  0
`define STAT_TXNFULL_BIT 1
`define STAT_TXEMPTY_BIT 2
`define STAT_RXNEMPTY_BIT 3

// Reset values and address constants.
`define CONTROL_RST      7'h00
`define SLAVE_ADDR_RST   10'h055
`define MASK_RST         7'h00
`define TENBIT_PREFIX    5'h1e

`endif

// file: shared/i2c_slave_pkg.sv
package i2c_slave_pkg;

  // Byte-level states of the slave engine.
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR2,
    ST_ACK,
    ST_RX,
    ST_TXWAIT,
    ST_TX,
    ST_TXACK,
    ST_SKIP
  } slv_state_type;

endpackage

// file: hdl/i2c_slave_clock_sync.sv
// Summary of operation
// - Clock release waits for line to rise.
// - High time counted from observed rising edge.
// - Data sampled only while clock high.
// - Slave may stretch by holding clock low.
// - Respond only to programmed seven- or ten-bit address.
// - Control bit three selects address width.
// - Slave only when both mode bits zero.
// - Configuration kept while disabled.
// - Read address sets request, stretches clock.
// - Mask gates output and raw-read clear, raw still sets.
// - Stale transmit data aborts and flushes.
// - Flushed state kept until abort-clear read.
// - Masked raw read clears set request and abort flags.
// - Data ready and flags clear release clock.
// - Write address: acknowledge, store each byte.
// - Full receive buffer flags overflow, still acknowledges.
// - Receive-full raw bit gated by threshold.
// - Status shows receive not empty; read data.
// - Seven-bit byte: address high, direction low.
// - Ten-bit prefix byte then low address byte.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "i2c_slave_defines.svh"
module i2c_slave_clock_sync #(
  parameter int TX_DEPTH = 8,
  parameter int RX_DEPTH = 8
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        arst_n,
  // APB slave.
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Two-wire bus pins.
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe
);
  import i2c_slave_pkg::*;

  localparam int TAW = $clog2(TX_DEPTH);
  localparam int RAW = $clog2(RX_DEPTH);
  localparam int TCW = $clog2(TX_DEPTH + 1);
  localparam int RCW = $clog2(RX_DEPTH + 1);

  typedef struct packed {
    logic                         sclM, sclS, sclP;
    logic                         sdaM, sdaS, sdaP;
    logic [31:0]                  rdata;
    logic                         rdy, err;
    logic [6:0]                   ctrl;
    logic [9:0]                   sar;
    logic [6:0]                   mask;
    logic [RCW-1:0]               rxTl;
    logic                         en;
    logic                         rxOver, rdReq, abrt, txLocked;
    logic [TX_DEPTH-1:0][7:0]     txMem;
    logic [TAW-1:0]               txRd, txWr;
    logic [TCW-1:0]               txCnt;
    logic [RX_DEPTH-1:0][7:0]     rxMem;
    logic [RAW-1:0]               rxRd, rxWr;
    logic [RCW-1:0]               rxCnt;
    slv_state_type                st, nextSt;
    logic [7:0]                   sh;
    logic [3:0]                   bitCnt;
    logic                         tenHit, isRead;
    logic                         sclOe, sdaOe;
  } state_type;

  state_type q, d;
  logic [1:0] rstPipe;
  logic       rstN;
  logic       sclRise, sclFall, startDet, stopDet;
  logic       setup, acc, act;
  logic [6:0] raw;
  logic       txPush, txPop, txFlush, rxPush, rxPop;
  logic       setRd, setAbrt, setOver;

  // Tells whether an offset belongs to a mapped register.
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      `CONTROL_REG_OFS, `SLAVE_ADDRESS_REG_OFS, `DATA_CMD_REG_OFS,
      `MASKED_STATUS_REG_OFS, `INTERRUPT_MASK_REG_OFS, `RAW_STATUS_REG_OFS,
      `FIFO_THRESHOLD_REG_OFS, `CLEAR_OVERFLOW_REG_OFS, `CLEAR_READREQ_REG_OFS,
      `CLEAR_ABORT_REG_OFS, `ENABLE_REG_OFS, `STATUS_REG_OFS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // Releases the reset through two flip-flops.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstN = rstPipe[1];

  // Bus events seen on the synchronised pins; edges follow the real line level.
  assign sclRise  = q.sclS & ~q.sclP;
  assign sclFall  = ~q.sclS & q.sclP;
  assign startDet = q.sclS & q.sclP & q.sdaP & ~q.sdaS;
  assign stopDet  = q.sclS & q.sclP & ~q.sdaP & q.sdaS;
  assign setup    = psel & ~penable;
  assign acc      = psel & penable & q.rdy;
  assign act      = q.en & ~q.ctrl[`CTRL_SLVDIS_BIT] & ~q.ctrl[`CTRL_MASTER_BIT];

  // Raw status vector; receive-full compares the level with the threshold.
  always_comb begin
    raw = 7'h00;
    raw[`ST_RXOVER_BIT] = q.rxOver;
    raw[`ST_RXFULL_BIT] = q.rxCnt > q.rxTl;
    raw[`ST_RDREQ_BIT]  = q.rdReq;
    raw[`ST_ABORT_BIT]  = q.abrt;
  end

  // Next-state logic: synchronisers, APB slave, FIFOs and the byte engine.
  always_comb begin
    d = q;
    txPush = 1'b0;
    txPop = 1'b0;
    txFlush = 1'b0;
    rxPush = 1'b0;
    rxPop = 1'b0;
    setRd = 1'b0;
    setAbrt = 1'b0;
    setOver = 1'b0;
    d.sclM = sclIn;
    d.sclS = q.sclM;
    d.sclP = q.sclS;
    d.sdaM = sdaIn;
    d.sdaS = q.sdaM;
    d.sdaP = q.sdaS;
    // Read data and error are latched in the setup cycle, ready follows.
    d.rdy = setup;
    d.err = 1'b0;
    if (setup) begin
      d.err = ~mapped(paddr);
      case (paddr)
        `CONTROL_REG_OFS:        d.rdata = 32'(q.ctrl);
        `SLAVE_ADDRESS_REG_OFS:  d.rdata = 32'(q.sar);
        `DATA_CMD_REG_OFS:       d.rdata = 32'(q.rxMem[q.rxRd]);
        `MASKED_STATUS_REG_OFS:  d.rdata = 32'(raw & q.mask);
        `INTERRUPT_MASK_REG_OFS: d.rdata = 32'(q.mask);
        `RAW_STATUS_REG_OFS:     d.rdata = 32'(raw);
        `FIFO_THRESHOLD_REG_OFS: d.rdata = 32'(q.rxTl);
        `ENABLE_REG_OFS:         d.rdata = 32'(q.en);
        `STATUS_REG_OFS:         d.rdata = 32'({q.rxCnt != '0, q.txCnt == '0,
                                                q.txCnt != TCW'(TX_DEPTH), q.st != ST_IDLE});
        default:                 d.rdata = 32'h0000_0000;
      endcase
    end
    // Writes; control, address and threshold change only while disabled, the mask at any time; none is ever cleared.
    if (acc && pwrite && !q.err) begin
      case (paddr)
        `CONTROL_REG_OFS:        if (!q.en) d.ctrl = pwdata[6:0];
        `SLAVE_ADDRESS_REG_OFS:  if (!q.en) d.sar = pwdata[9:0];
        `FIFO_THRESHOLD_REG_OFS: if (!q.en) d.rxTl = pwdata[RCW-1:0];
        `INTERRUPT_MASK_REG_OFS: d.mask = pwdata[6:0];
        `ENABLE_REG_OFS:         d.en = pwdata[0];
        `DATA_CMD_REG_OFS:       txPush = !pwdata[`DATA_CMD_BIT] && q.en && !q.txLocked &&
                                          q.txCnt != TCW'(TX_DEPTH);
        default:                 d.en = q.en;
      endcase
    end
    // Read side effects: pops and flag clears, set below wins.
    if (acc && !pwrite && !q.err) begin
      case (paddr)
        `DATA_CMD_REG_OFS:       rxPop = q.rxCnt != '0;
        `CLEAR_OVERFLOW_REG_OFS: d.rxOver = 1'b0;
        `CLEAR_READREQ_REG_OFS:  d.rdReq = 1'b0;
        `CLEAR_ABORT_REG_OFS: begin
          d.abrt = 1'b0;
          d.txLocked = 1'b0;
        end
        `RAW_STATUS_REG_OFS: begin
          if (q.rdata[`ST_RDREQ_BIT] && !q.mask[`ST_RDREQ_BIT]) d.rdReq = 1'b0;
          if (q.rdata[`ST_ABORT_BIT] && !q.mask[`ST_ABORT_BIT]) d.abrt = 1'b0;
        end
        default:                 d.en = d.en;
      endcase
    end
    // Byte engine.
    if (!act) begin
      d.st = ST_IDLE;
      d.sclOe = 1'b0;
      d.sdaOe = 1'b0;
      d.tenHit = 1'b0;
      txFlush = !q.en;
    end else if (startDet) begin
      d.st = ST_ADDR;
      d.bitCnt = 4'h0;
      d.sclOe = 1'b0;
      d.sdaOe = 1'b0;
    end else if (stopDet) begin
      d.st = ST_IDLE;
      d.sclOe = 1'b0;
      d.sdaOe = 1'b0;
      d.tenHit = 1'b0;
    end else begin
      case (q.st)
        ST_ADDR, ST_ADDR2, ST_RX: begin
          if (sclRise) begin
            d.sh = {q.sh[6:0], q.sdaS};
            d.bitCnt = q.bitCnt + 4'h1;
          end
          if (sclFall && q.bitCnt == 4'h8) begin
            d.sdaOe = 1'b1;
            d.st = ST_ACK;
            d.nextSt = ST_RX;
            d.isRead = 1'b0;
            if (q.st == ST_RX) begin
              rxPush = 1'b1;
            end else if (q.st == ST_ADDR2) begin
              if (q.sh == q.sar[7:0]) begin
                d.tenHit = 1'b1;
              end else begin
                d.sdaOe = 1'b0;
                d.st = ST_SKIP;
              end
            end else if (q.ctrl[`CTRL_TENBIT_BIT] ? (q.sh[7:3] == `TENBIT_PREFIX &&
                         q.sh[2:1] == q.sar[9:8] && (!q.sh[0] || q.tenHit))
                         : q.sh[7:1] == q.sar[6:0]) begin
              if (!q.sh[0]) begin
                d.nextSt = q.ctrl[`CTRL_TENBIT_BIT] ? ST_ADDR2 : ST_RX;
              end else begin
                d.nextSt = ST_TXWAIT;
                d.isRead = 1'b1;
                setRd = 1'b1;
                if (q.txCnt != '0) begin
                  setAbrt = 1'b1;
                  txFlush = 1'b1;
                end
              end
            end else begin
              d.sdaOe = 1'b0;
              d.st = ST_SKIP;
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            d.sdaOe = 1'b0;
            d.bitCnt = 4'h0;
            d.st = q.nextSt;
            d.sclOe = q.nextSt == ST_TXWAIT;
          end
        end
        ST_TXWAIT: begin
          if (q.txCnt != '0 && !q.rdReq && !q.abrt) begin
            txPop = 1'b1;
            d.sh = q.txMem[q.txRd];
            d.bitCnt = 4'h0;
            d.sdaOe = ~q.txMem[q.txRd][7];
            d.sclOe = 1'b0;
            d.st = ST_TX;
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (q.bitCnt == 4'h7) begin
              d.sdaOe = 1'b0;
              d.st = ST_TXACK;
            end else begin
              d.bitCnt = q.bitCnt + 4'h1;
              d.sh = {q.sh[6:0], 1'b0};
              d.sdaOe = ~q.sh[6];
            end
          end
        end
        ST_TXACK: begin
          if (sclRise) begin
            d.bitCnt = 4'h8;
            if (q.sdaS) begin
              d.st = ST_SKIP;
              if (q.txCnt != '0) begin
                setAbrt = 1'b1;
                txFlush = 1'b1;
              end
            end
          end else if (sclFall && q.bitCnt == 4'h8) begin
            d.st = ST_TXWAIT;
            d.sclOe = 1'b1;
            setRd = q.txCnt == '0;
          end
        end
        default: d.st = q.st;
      endcase
    end
    // Hardware events set their flags after any clear in the same cycle.
    if (setRd) d.rdReq = 1'b1;
    if (setAbrt) begin
      d.abrt = 1'b1;
      d.txLocked = 1'b1;
    end
    // Transmit FIFO bookkeeping.
    if (txFlush) begin
      d.txRd = '0;
      d.txWr = '0;
      d.txCnt = '0;
    end else begin
      if (txPush) begin
        d.txMem[q.txWr] = pwdata[7:0];
        d.txWr = q.txWr + TAW'(1);
      end
      if (txPop) d.txRd = q.txRd + TAW'(1);
      d.txCnt = q.txCnt + TCW'(txPush) - TCW'(txPop);
    end
    // Receive FIFO bookkeeping; a byte finding it full is dropped unless a pop frees a place in the same cycle.
    setOver = rxPush && q.rxCnt == RCW'(RX_DEPTH) && !rxPop;
    if (!q.en) begin
      d.rxRd = '0;
      d.rxWr = '0;
      d.rxCnt = '0;
    end else begin
      if (rxPush && !setOver) begin
        d.rxMem[q.rxWr] = q.sh;
        d.rxWr = q.rxWr + RAW'(1);
      end
      if (rxPop) d.rxRd = q.rxRd + RAW'(1);
      d.rxCnt = q.rxCnt + RCW'(rxPush && !setOver) - RCW'(rxPop);
    end
    if (setOver) d.rxOver = 1'b1;
  end

  // State register.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      q <= '0;
      q.sclM <= 1'b1;
      q.sclS <= 1'b1;
      q.sclP <= 1'b1;
      q.sdaM <= 1'b1;
      q.sdaS <= 1'b1;
      q.sdaP <= 1'b1;
      q.ctrl <= `CONTROL_RST;
      q.sar <= `SLAVE_ADDR_RST;
      q.mask <= `MASK_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs; the pins only ever pull low.
  assign prdata  = q.rdata;
  assign pready  = q.rdy;
  assign pslverr = q.err;
  assign sclOe   = q.sclOe;
  assign sdaOe   = q.sdaOe;
  assign sclOut  = 1'b0;
  assign sdaOut  = 1'b0;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  // Checks next to the logic above.
  chk_stretch_held: assert property (q.st == ST_TXWAIT |-> q.sclOe)
    else $error("clock not held low while waiting for data");
  chk_rdreq_raised: assert property ((q.st == ST_ADDR && d.st == ST_ACK && d.isRead)
    |=> q.rdReq && q.sdaOe && raw[`ST_RDREQ_BIT])
    else $error("read address did not raise the request");
  chk_abort_flush: assert property ((q.st == ST_ADDR && d.isRead && d.st == ST_ACK && q.txCnt != '0)
    |=> q.abrt && q.txLocked && q.txCnt == '0)
    else $error("stale data not flushed on read request");
  chk_locked_push: assert property ((q.txLocked && !txFlush && !txPop) |=> q.txCnt == $past(q.txCnt))
    else $error("write accepted while transmit buffer locked");
  chk_raw_clear: assert property ((acc && !pwrite && paddr == `RAW_STATUS_REG_OFS &&
    q.rdata[`ST_RDREQ_BIT] && !q.mask[`ST_RDREQ_BIT] && !setRd) |=> !q.rdReq)
    else $error("masked raw read did not clear request");
  chk_release_tx: assert property ((q.st == ST_TXWAIT && act && !startDet && !stopDet &&
    q.txCnt != '0 && !q.rdReq && !q.abrt) |=> !q.sclOe && q.st == ST_TX ##1 q.sclOe == 1'b0)
    else $error("clock not released with data ready");
  chk_overflow_keep: assert property ((rxPush && q.en && q.rxCnt == RCW'(RX_DEPTH) && !rxPop)
    |=> q.rxOver && q.rxCnt == $past(q.rxCnt) && q.rxWr == $past(q.rxWr))
    else $error("overflow byte not dropped or flag not set");
  chk_rx_store: assert property ((rxPush && q.en && q.rxCnt < RCW'(RX_DEPTH) && !rxPop)
    |=> q.rxCnt == $past(q.rxCnt) + RCW'(1))
    else $error("received byte not stored");
  chk_masked_read: assert property ((setup && paddr == `MASKED_STATUS_REG_OFS)
    |=> prdata[`ST_RXFULL_BIT] == ($past(q.rxCnt > q.rxTl) && $past(q.mask[`ST_RXFULL_BIT])))
    else $error("masked receive-full bit wrong");
  chk_ack_drive: assert property (q.st == ST_ACK |-> q.sdaOe)
    else $error("acknowledge not driven after match");
endmodule

// file: tb/remote_master.sv
`timescale 1ns/100ps
module remote_master #(
  parameter int HALF_NS = 80
) (
  // Resolved bus lines.
  input  wire logic sclLine,
  input  wire logic sdaLine,
  // Open-drain pulls, high pulls the line low.
  output logic      sclPull,
  output logic      sdaPull
);
  // Both lines are released while no frame runs.
  initial begin
    sclPull = 1'b0;
    sdaPull = 1'b0;
  end

  // Releases the clock, waits while anyone still holds it low, then counts high time from the seen rise.
  task automatic clockHigh(output logic bitSeen);
    sclPull = 1'b0;
    wait (sclLine === 1'b1);
    #(HALF_NS / 2);
    bitSeen = sdaLine;
    #(HALF_NS / 2);
    sclPull = 1'b1;
    #(HALF_NS / 4);
  endtask

  // A start condition: data falls while the clock is high.
  task automatic start();
    sdaPull = 1'b1;
    #(HALF_NS);
    sclPull = 1'b1;
    #(HALF_NS / 4);
  endtask

  // Sends one byte most significant bit first and returns the acknowledge seen.
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sdaPull = ~b[i];
      #(HALF_NS * 3 / 4);
      clockHigh(s);
    end
    sdaPull = 1'b0;
    #(HALF_NS * 3 / 4);
    clockHigh(s);
    ack = ~s;
  endtask

  // Receives one byte, then acknowledges it or not.
  task automatic recvByte(output logic [7:0] b, input logic ackIt);
    logic s;
    sdaPull = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #(HALF_NS * 3 / 4);
      clockHigh(s);
      b[i] = s;
    end
    sdaPull = ackIt;
    #(HALF_NS * 3 / 4);
    clockHigh(s);
  endtask

  // A stop condition: data rises while the clock is high.
  task automatic stop();
    sdaPull = 1'b1;
    #(HALF_NS * 3 / 4);
    sclPull = 1'b0;
    wait (sclLine === 1'b1);
    #(HALF_NS);
    sdaPull = 1'b0;
    #(HALF_NS);
  endtask
endmodule

// file: tb/i2c_slave_clock_sync_tb.sv
`timescale 1ns/100ps
`include "i2c_slave_defines.svh"
module i2c_slave_clock_sync_tb;
  localparam int RX_DEPTH = 8;
  localparam int LIMIT    = 20000;
  // Clock, reset and bus signals.
  logic        clk;
  logic        arst_n;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sclOut;
  logic        sclOe;
  logic        sdaOut;
  logic        sdaOe;
  logic        mSclPull;
  logic        mSdaPull;
  logic        sclLine;
  logic        sdaLine;
  logic [31:0] rd;
  logic        err;
  logic        ack;
  logic [7:0]  rxb;
  int          mismatches;
  int          checked;
  int          cycles;

  // Wired-AND lines with pull-ups.
  assign sclLine = (sclOe ? sclOut : 1'b1) & ~mSclPull;
  assign sdaLine = (sdaOe ? sdaOut : 1'b1) & ~mSdaPull;

  always #5 clk = ~clk;

  i2c_slave_clock_sync #(.TX_DEPTH(8), .RX_DEPTH(RX_DEPTH)) DUT (
    .clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(sclLine),
    .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe)
  );

  remote_master remote (
    .sclLine(sclLine), .sdaLine(sdaLine), .sclPull(mSclPull), .sdaPull(mSdaPull)
  );

  // Ends the run with the counts and the verdict.
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer: setup, then access held until pready is seen high.
  task automatic apbXfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                         output logic [31:0] d, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apbXfer(1'b1, a, wd, rd, err);
  endtask

  task automatic checkReg(input logic [7:0] a, input logic [31:0] exp);
    apbXfer(1'b0, a, 32'h0, rd, err);
    checkVal(rd, exp);
  endtask

  // Runs a read frame; software services the stretched clock alongside.
  task automatic readFrame(input logic [31:0] rawFirst, input logic [31:0] rawAgain,
                           input logic [31:0] msk, input logic [31:0] txByte);
    remote.start();
    remote.sendByte({7'h2a, 1'b1}, ack);
    checkVal({31'h0, ack}, 32'h1);
    fork
      remote.recvByte(rxb, 1'b0);
      begin
        repeat (20) @(posedge clk);
        checkVal({31'h0, sclOe}, 32'h1);
        checkReg(`MASKED_STATUS_REG_OFS, rawFirst & msk);
        checkReg(`RAW_STATUS_REG_OFS, rawFirst);
        checkReg(`RAW_STATUS_REG_OFS, rawAgain);
        wr(`DATA_CMD_REG_OFS, txByte);
        checkReg(`STATUS_REG_OFS, rawFirst[6] ? 32'h7 : 32'h3);
        apbXfer(1'b0, `CLEAR_ABORT_REG_OFS, 32'h0, rd, err);
        apbXfer(1'b0, `CLEAR_READREQ_REG_OFS, 32'h0, rd, err);
        // Supplies the byte again only when the locked buffer dropped it; a spare byte would abort on the NACK.
        if (rawFirst[6]) wr(`DATA_CMD_REG_OFS, txByte);
      end
    join
    checkVal({24'h0, rxb}, txByte);
    remote.stop();
  endtask

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    mismatches = 0;
    checked = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values and an unmapped access.
    checkReg(`CONTROL_REG_OFS, 32'h0);
    checkReg(`SLAVE_ADDRESS_REG_OFS, 32'h55);
    checkReg(`INTERRUPT_MASK_REG_OFS, 32'h0);
    apbXfer(1'b0, 8'h04, 32'h0, rd, err);
    checkVal({31'h0, err}, 32'h1);
    $display("test reset done");
    // Slave-only setup while disabled, then a write frame that overflows.
    wr(`SLAVE_ADDRESS_REG_OFS, 32'h2a);
    wr(`CONTROL_REG_OFS, 32'h0);
    wr(`ENABLE_REG_OFS, 32'h1);
    remote.start();
    remote.sendByte({7'h2a, 1'b0}, ack);
    checkVal({31'h0, ack}, 32'h1);
    for (int i = 0; i <= RX_DEPTH; i++) begin
      remote.sendByte(8'h10 + 8'(i), ack);
      checkVal({31'h0, ack}, 32'h1);
    end
    remote.stop();
    checkReg(`STATUS_REG_OFS, 32'he);
    checkReg(`RAW_STATUS_REG_OFS, 32'h6);
    for (int i = 0; i < RX_DEPTH; i++) begin
      checkReg(`DATA_CMD_REG_OFS, 32'h10 + i);
    end
    checkReg(`STATUS_REG_OFS, 32'h6);
    apbXfer(1'b0, `CLEAR_OVERFLOW_REG_OFS, 32'h0, rd, err);
    checkReg(`RAW_STATUS_REG_OFS, 32'h0);
    $display("test receive done");
    // A foreign address gets no acknowledge.
    remote.start();
    remote.sendByte({7'h2b, 1'b0}, ack);
    checkVal({31'h0, ack}, 32'h0);
    remote.stop();
    $display("test foreign address done");
    // Read with stale transmit data, flags masked.
    wr(`DATA_CMD_REG_OFS, 32'ha5);
    readFrame(32'h60, 32'h0, 32'h0, 32'h3c);
    // Read with the request unmasked: raw read does not clear it.
    wr(`INTERRUPT_MASK_REG_OFS, 32'h20);
    readFrame(32'h20, 32'h20, 32'h20, 32'h96);
    $display("test transmit done");
    // Ten-bit addressing with a raised receive threshold.
    wr(`ENABLE_REG_OFS, 32'h0);
    wr(`CONTROL_REG_OFS, 32'h8);
    wr(`SLAVE_ADDRESS_REG_OFS, 32'h2a5);
    wr(`FIFO_THRESHOLD_REG_OFS, 32'h1);
    wr(`ENABLE_REG_OFS, 32'h1);
    checkReg(`INTERRUPT_MASK_REG_OFS, 32'h20);
    checkReg(`SLAVE_ADDRESS_REG_OFS, 32'h2a5);
    remote.start();
    remote.sendByte({`TENBIT_PREFIX, 2'b10, 1'b0}, ack);
    checkVal({31'h0, ack}, 32'h1);
    remote.sendByte(8'ha5, ack);
    checkVal({31'h0, ack}, 32'h1);
    remote.sendByte(8'h77, ack);
    checkVal({31'h0, ack}, 32'h1);
    remote.stop();
    checkReg(`RAW_STATUS_REG_OFS, 32'h0);
    checkReg(`DATA_CMD_REG_OFS, 32'h77);
    $display("test ten-bit done");
    // Slave side disabled: the programmed address is ignored.
    wr(`ENABLE_REG_OFS, 32'h0);
    wr(`CONTROL_REG_OFS, 32'h48);
    wr(`ENABLE_REG_OFS, 32'h1);
    checkReg(`CONTROL_REG_OFS, 32'h48);
    remote.start();
    remote.sendByte({`TENBIT_PREFIX, 2'b10, 1'b0}, ack);
    checkVal({31'h0, ack}, 32'h0);
    remote.stop();
    $display("test slave disable done");
    print_verdict();
  end
endmodule
